// File: design/pmem_array.sv
// Flash program word array with synchronous read and word-wide synchronous write port
`timescale 1ns/100ps
`include "pmem_regs.svh"

module pmem_array #(
    parameter int DEPTH  = `PMEM_DEPTH,
    parameter int ADDR_W = `PMEM_ADDR_W,
    parameter int WORD_W = `PMEM_WORD_W
) (
    // Clock
    input  wire logic              clk,
    // Read port
    input  wire logic [ADDR_W-1:0] readAddr,
    output logic      [WORD_W-1:0] readData,
    // Write port
    input  wire logic              writeEn,
    input  wire logic [ADDR_W-1:0] writeAddr,
    input  wire logic [WORD_W-1:0] writeData
);
    // Storage shared by code, tables and vectors
    logic [WORD_W-1:0] mem [DEPTH];

    // Programming write
    always_ff @(posedge clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
    end

    // Registered read
    always_ff @(posedge clk) begin
        readData <= mem[readAddr];
    end
endmodule : pmem_array

// File: design/pmem_pkg.sv
// Types shared by the program memory table read block
package pmem_pkg;
    typedef enum logic [1:0] {
        TR_IDLE   = 2'b00,
        TR_ACCESS = 2'b01,
        TR_XFER   = 2'b10
    } table_state_e;
endpackage : pmem_pkg

// File: design/pmem_regs.svh
// Constants and summary for the program memory table read block
//
// Summary of operation
// - Program store holds 4096 words of 16 bits, shared by code and tables.
// - After reset, instruction fetch starts at program address zero.
// - Table data anywhere, addressed by a table pointer separate from the PC.
// - Full table read address: high pointer bits 11..8, low pointer bits 7..0.
// - Last-page table read forces address bits 11..8 to ones.
// - Low byte goes to the named data register, high byte to the latch.
// - High byte bits without stored program bits read as zero.
// - Every table read takes two instruction cycles to finish.
// - Table-high latch is read-only; software writes never change it.
// - Serial in-circuit programming: one two-way data pin, clock from programmer.
// - While debugging on emulation part, functions shared on debug pins are inactive.
// - Debug pins still act as in-circuit programming data and clock pins.
`ifndef PMEM_REGS_SVH
`define PMEM_REGS_SVH

// ----------------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------------
`define PMEM_DEPTH        4096
`define PMEM_ADDR_W       12
`define PMEM_WORD_W       16
`define PMEM_RESET_VECTOR 12'h000
`define PMEM_LAST_PAGE    4'hF
`define PMEM_TABLE_HIGH_LATCH_RESET   8'h00
`define PMEM_ERASED_WORD  16'hFFFF
`define PMEM_READ_CYCLES  2

`endif

// File: design/program_memory_table_read.sv
// Program memory access: fetch, table reads, in-circuit programming pins
`timescale 1ns/100ps
`include "pmem_regs.svh"

module program_memory_table_read #(
    parameter int ADDR_W   = `PMEM_ADDR_W,
    parameter int WORD_W   = `PMEM_WORD_W,
    parameter int STORED_W = `PMEM_WORD_W
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Instruction fetch
    input  wire logic              fetchEn,
    input  wire logic [ADDR_W-1:0] fetchAddr,
    output logic [ADDR_W-1:0]      pcStart,
    output logic [WORD_W-1:0]      fetchWord,
    output logic                   fetchValid,
    // Table read request from core
    input  wire logic              tableReq,
    input  wire logic              tableLastPage,
    input  wire logic [7:0]        tablePtrLow,
    input  wire logic [3:0]        tablePtrHigh,
    input  wire logic [7:0]        tableDestIn,
    output logic                   tableBusy,
    output logic                   tableDone,
    output logic [7:0]             tableDest,
    output logic [7:0]             tableLowByte,
    output logic [7:0]             table_high_latch,
    // Software write attempt to the latch
    input  wire logic              latchWrite,
    input  wire logic [7:0]        latchWriteData,
    // Serial programming and debug pins
    input  wire logic              debugMode,
    input  wire logic              progEnable,
    input  wire logic              prog_serial_clock,
    input  wire logic              prog_serial_data_in,
    output logic                   prog_serial_data_out,
    output logic                   prog_serial_data_oe,
    input  wire logic              progWriteEn,
    input  wire logic [ADDR_W-1:0] progAddr,
    input  wire logic [WORD_W-1:0] progData,
    input  wire logic              progReadReq,
    input  wire logic              progReadBit,
    // Pin-shared user functions
    input  wire logic              gpioOut,
    input  wire logic              gpioOe,
    output logic                   sharedPinOut,
    output logic                   sharedPinOe,
    output logic                   sharedFuncEn,
    output logic                   progClockSeen
);
    // ------------------------------------------------------------------------
    // Table read sequencing
    // ------------------------------------------------------------------------
    pmem_pkg::table_state_e state;
    pmem_pkg::table_state_e next_state;
    logic [ADDR_W-1:0] tableAddr;
    logic [ADDR_W-1:0] arrayAddr;
    logic [WORD_W-1:0] arrayData;
    logic [7:0]        destHold;
    logic              fetchPending;
    logic [WORD_W-1:0] maskedWord;

    // Table address from pointer, separate from the PC
    always_comb begin
        if (tableLastPage) begin
            tableAddr = {`PMEM_LAST_PAGE, tablePtrLow};
        end else begin
            tableAddr = {tablePtrHigh, tablePtrLow};
        end
    end

    // Array port steering; programming first unless a table read is busy, then a new table request, else fetch
    always_comb begin
        if (progEnable && !tableBusy) begin
            arrayAddr = progAddr;
        end else if (state == pmem_pkg::TR_IDLE && tableReq) begin
            arrayAddr = tableAddr;
        end else begin
            arrayAddr = fetchAddr;
        end
    end

    // Bits with no stored cell read as zero
    generate
        for (genvar b = 0; b < WORD_W; b++) begin : g_mask
            if (b < STORED_W) begin : g_keep
                assign maskedWord[b] = arrayData[b];
            end else begin : g_zero
                assign maskedWord[b] = 1'b0;
            end
        end
    endgenerate

    pmem_array #(
        .DEPTH  (`PMEM_DEPTH),
        .ADDR_W (ADDR_W),
        .WORD_W (WORD_W)
    ) u_array (
        .clk       (clk),
        .readAddr  (arrayAddr),
        .readData  (arrayData),
        .writeEn   (progEnable && progWriteEn),
        .writeAddr (progAddr),
        .writeData (progData)
    );

    // Two-cycle sequence: access, then byte transfers
    always_comb begin
        next_state = state;
        unique case (state)
            pmem_pkg::TR_IDLE: begin
                if (tableReq) next_state = pmem_pkg::TR_ACCESS;
            end
            pmem_pkg::TR_ACCESS: begin
                next_state = pmem_pkg::TR_XFER;
            end
            pmem_pkg::TR_XFER: begin
                next_state = pmem_pkg::TR_IDLE;
            end
            default: next_state = pmem_pkg::TR_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) state <= pmem_pkg::TR_IDLE;
        else     state <= next_state;
    end

    // Destination capture at request
    always_ff @(posedge clk) begin
        if (rst) begin
            destHold <= 8'h00;
        end else if (state == pmem_pkg::TR_IDLE && tableReq) begin
            destHold <= tableDestIn;
        end
    end

    // Busy flag spans both instruction cycles
    always_ff @(posedge clk) begin
        if (rst) tableBusy <= 1'b0;
        else     tableBusy <= (next_state != pmem_pkg::TR_IDLE);
    end

    // Byte transfers in second cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            tableDone    <= 1'b0;
            tableDest    <= 8'h00;
            tableLowByte <= 8'h00;
        end else begin
            tableDone <= (state == pmem_pkg::TR_ACCESS);
            if (state == pmem_pkg::TR_ACCESS) begin
                tableDest    <= destHold;
                tableLowByte <= maskedWord[7:0];
            end
        end
    end

    // Latch changes only on a table read; software writes ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            table_high_latch <= `PMEM_TABLE_HIGH_LATCH_RESET;
        end else if (state == pmem_pkg::TR_ACCESS) begin
            table_high_latch <= maskedWord[15:8];
        end
    end
    // latchWrite and latchWriteData are deliberately unused: read-only latch
    logic unusedWrite;
    assign unusedWrite = latchWrite & (|latchWriteData);

    // ------------------------------------------------------------------------
    // Instruction fetch
    // ------------------------------------------------------------------------
    // Fetch data is two cycles after the request; a table access drops it
    always_ff @(posedge clk) begin
        if (rst) begin
            fetchPending <= 1'b0;
            fetchValid   <= 1'b0;
            fetchWord    <= `PMEM_ERASED_WORD;
            pcStart      <= `PMEM_RESET_VECTOR;
        end else begin
            fetchPending <= fetchEn && !(state == pmem_pkg::TR_IDLE && tableReq)
                            && !progEnable;
            fetchValid   <= fetchPending && (state == pmem_pkg::TR_IDLE);
            fetchWord    <= arrayData;
            pcStart      <= `PMEM_RESET_VECTOR;
        end
    end

    // ------------------------------------------------------------------------
    // Serial programming and debug pin sharing
    // ------------------------------------------------------------------------
    // Readback drives the data pin only while programmer asks for it
    always_ff @(posedge clk) begin
        if (rst) begin
            prog_serial_data_out <= 1'b0;
            prog_serial_data_oe  <= 1'b0;
            progClockSeen        <= 1'b0;
        end else begin
            prog_serial_data_out <= progReadBit;
            prog_serial_data_oe  <= progEnable && progReadReq;
            progClockSeen        <= progEnable && prog_serial_clock && prog_serial_data_in;
        end
    end

    // User functions lose the pins during debug or programming
    always_ff @(posedge clk) begin
        if (rst) begin
            sharedFuncEn <= 1'b1;
            sharedPinOut <= 1'b0;
            sharedPinOe  <= 1'b0;
        end else begin
            sharedFuncEn <= !(debugMode || progEnable);
            sharedPinOut <= (debugMode || progEnable) ? 1'b0 : gpioOut;
            sharedPinOe  <= (debugMode || progEnable) ? 1'b0 : gpioOe;
        end
    end
endmodule : program_memory_table_read

// File: test/core_model.sv
// Core-side model issuing table read requests
`timescale 1ns/100ps

module core_model (
    // Clock and answer
    input  wire logic clk,
    input  wire logic tableDone,
    // Request
    output logic       tableReq,
    output logic       tableLastPage,
    output logic [7:0] tablePtrLow,
    output logic [3:0] tablePtrHigh,
    output logic [7:0] tableDestIn
);
    // Idle at time zero
    initial {tableReq, tableLastPage, tablePtrHigh, tablePtrLow, tableDestIn} = '0;

    // One read; pointer scrambled once taken, so a late sample shows up
    task automatic rd(input logic lp, input logic [11:0] a, input logic [7:0] d,
                      output int n);
        @(negedge clk);
        {tableLastPage, tablePtrHigh, tablePtrLow, tableDestIn} = {lp, a, d};
        tableReq = 1'b1;
        @(negedge clk);
        tableReq = 1'b0;
        {tableLastPage, tablePtrHigh, tablePtrLow, tableDestIn} = ~{lp, a, d};
        n = 1;
        while (tableDone !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
    endtask : rd
endmodule : core_model

// File: test/pmtr_properties.sv
// Port checks for the program memory table read block
`timescale 1ns/100ps

module pmtr_properties #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Table read
    input wire logic              tableReq,
    input wire logic              tableBusy,
    input wire logic              tableDone,
    input wire logic [7:0]        table_high_latch,
    input wire logic [7:0]        tableLowByte,
    input wire logic [ADDR_W-1:0] pcStart,
    // Programming and debug
    input wire logic              debugMode,
    input wire logic              progEnable,
    input wire logic              progReadReq,
    input wire logic              progReadBit,
    input wire logic              prog_serial_data_oe,
    input wire logic              prog_serial_data_out,
    // Shared pins
    input wire logic              sharedPinOe,
    input wire logic              sharedFuncEn
);
    // All checks on the one clock, quiet in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_entry_zero: assert property (pcStart == 12'h000)
        else $error("entry point not zero");
    a_busy_span: assert property (tableReq && !tableBusy |=>
        tableBusy ##1 tableBusy ##1 !tableBusy) else $error("busy span wrong");
    a_done_time: assert property (tableReq && !tableBusy |=>
        !tableDone ##1 tableDone ##1 !tableDone) else $error("done timing wrong");
    a_latch_hold: assert property (!tableDone |-> $stable(table_high_latch))
        else $error("latch changed outside a read");
    a_low_hold: assert property (!tableDone |-> $stable(tableLowByte))
        else $error("low byte changed outside a read");
    a_pins_quiet: assert property (debugMode || progEnable |=>
        !sharedPinOe && !sharedFuncEn) else $error("shared pin active in debug");
    a_func_back: assert property (!debugMode && !progEnable |=> sharedFuncEn)
        else $error("shared function not restored");
    a_prog_drive: assert property (progEnable && progReadReq |=>
        prog_serial_data_oe) else $error("programming pin not driven");
    a_prog_bit: assert property (progEnable && progReadReq |=>
        prog_serial_data_out == $past(progReadBit)) else $error("serial bit wrong");
endmodule : pmtr_properties

bind program_memory_table_read pmtr_properties #(.ADDR_W(ADDR_W)) chk (.*);

// File: test/program_memory_table_read_tb.sv
// Self-checking bench for the program memory table read block
`timescale 1ns/100ps

`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin nErrors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module program_memory_table_read_tb;
    logic        clk, rst, fetchEn, latchWrite, debugMode, progEnable, progWriteEn;
    logic        progReadReq, progReadBit, gpioOut, gpioOe, prog_serial_clock;
    logic        prog_serial_data_in, tableReq, tableLastPage, tableBusy, tableDone;
    logic        fetchValid, sharedPinOut, sharedPinOe, sharedFuncEn, progClockSeen;
    logic        prog_serial_data_out, prog_serial_data_oe;
    logic [11:0] fetchAddr, progAddr, pcStart;
    logic [15:0] progData, fetchWord;
    logic [7:0]  latchWriteData, tablePtrLow, tableDestIn, tableDest, tableLowByte;
    logic [7:0]  table_high_latch;
    logic [3:0]  tablePtrHigh;
    int          nErrors = 0, cmpCount = 0;

    program_memory_table_read uut (.*);
    core_model core (.*);

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Programming-port write of one word, whole word in one cycle
    task automatic prog(input logic [11:0] a, input logic [15:0] w);
        @(negedge clk);
        {progEnable, progWriteEn, progAddr, progData} = {2'b11, a, w};
        @(negedge clk);
        {progEnable, progWriteEn, progAddr, progData} = {2'b00, ~a, ~w};
    endtask : prog

    task automatic t_reset;
        `CHK(pcStart, 12'h000)
        `CHK({table_high_latch, tableBusy}, 9'h000)
    endtask : t_reset

    // Full and last-page reads, back to back
    task automatic t_reads;
        int n;
        prog(12'h3A5, 16'hC35A);
        prog(12'h306, 16'h7788);
        prog(12'hF06, 16'h1A2B);
        core.rd(1'b0, 12'h3A5, 8'h21, n);
        `CHK(n, 2)
        `CHK(tableBusy, 1'b1)
        `CHK({table_high_latch, tableLowByte}, 16'hC35A)
        `CHK(tableDest, 8'h21)
        core.rd(1'b1, 12'h306, 8'h22, n);
        `CHK({table_high_latch, tableLowByte, tableDest}, 24'h1A2B22)
        core.rd(1'b0, 12'h306, 8'h23, n);
        `CHK({table_high_latch, tableLowByte, tableDest}, 24'h778823)
    endtask : t_reads

    task automatic t_latch;
        @(negedge clk);
        {latchWrite, latchWriteData} = {1'b1, 8'h55};
        @(negedge clk);
        {latchWrite, latchWriteData} = {1'b0, 8'hAA};
        repeat (2) @(negedge clk);
        `CHK(table_high_latch, 8'h77)
    endtask : t_latch

    task automatic t_fetch;
        int k;
        @(negedge clk);
        {fetchEn, fetchAddr} = {1'b1, 12'hF06};
        @(negedge clk);
        {fetchEn, fetchAddr} = {1'b0, 12'h0F9};
        k = 0;
        while (fetchValid !== 1'b1 && k < 4) begin
            @(negedge clk);
            k++;
        end
        `CHK(fetchWord, 16'h1A2B)
        `CHK(fetchValid, 1'b1)
        `CHK(k, 1)
    endtask : t_fetch

    // Debug alone must free the shared pins; programming then rides on them
    task automatic t_pins;
        @(negedge clk);
        {debugMode, gpioOut, gpioOe} = 3'b111;
        repeat (2) @(negedge clk);
        `CHK({sharedPinOut, sharedPinOe, sharedFuncEn}, 3'b000)
        {progEnable, progReadReq, progReadBit, prog_serial_clock, prog_serial_data_in} = 5'h1F;
        repeat (2) @(negedge clk);
        `CHK({sharedPinOe, sharedFuncEn}, 2'b00)
        `CHK({prog_serial_data_oe, prog_serial_data_out}, 2'b11)
        `CHK(progClockSeen, 1'b1)
        {debugMode, progEnable, progReadReq, progReadBit, prog_serial_clock,
         prog_serial_data_in} = 6'h00;
        repeat (2) @(negedge clk);
        `CHK({sharedPinOut, sharedPinOe, sharedFuncEn}, 3'b111)
    endtask : t_pins

    // Mid-run reset: latch and entry point return to defined values
    task automatic t_mid_reset;
        int n;
        `CHK(table_high_latch, 8'h77)
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK({pcStart, table_high_latch, tableLowByte, tableBusy}, 29'h0)
        core.rd(1'b1, 12'h006, 8'h31, n);
        `CHK(n, 2)
        `CHK({table_high_latch, tableLowByte, tableDest}, 24'h1A2B31)
    endtask : t_mid_reset

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // Main sequence; unused serial pins held low, protocol not modelled
    initial begin
        {fetchEn, fetchAddr, latchWrite, latchWriteData, debugMode, progEnable,
         progWriteEn, progAddr, progData, progReadReq, progReadBit, gpioOut, gpioOe,
         prog_serial_clock, prog_serial_data_in} = '0;
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_reads;
        t_latch;
        t_fetch;
        t_pins;
        t_mid_reset;
        final_report;
    end

    // Watchdog at 20000 cycles, far beyond the few dozen cycles needed
    initial begin
        #2000000;
        nErrors++;
        final_report;
    end
endmodule : program_memory_table_read_tb
